// [ast_uart.sv]
// Asynchronous serial transceiver: tick generator, transmitter, receiver.
// Assumes RXD and CTS_N arrive from pins; user ports are on CLK.
`include "ast_defines.svh"
`timescale 1ns/1ps
module ast_uart #(
	parameter int DEPTH = `AST_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Configuration
	input wire logic ENABLE,
	input wire logic FIFO_ENABLE,
	input wire logic [`AST_INT_W-1:0] DIVISOR_INTEGER,
	input wire logic [`AST_FRAC_W-1:0] DIVISOR_FRACTION,
	input wire logic OVERSAMPLE_SELECT,
	input wire ast_pkg::ast_line_t TX_LINE_CONTROL,
	input wire ast_pkg::ast_line_t RX_LINE_CONTROL,
	input wire logic RTS_FLOW_ENABLE,
	input wire logic CTS_FLOW_ENABLE,
	input wire logic [$clog2(DEPTH):0] RX_WATERMARK,
	input wire logic XOFF_HOLD,
	// Transmit data
	input wire logic TX_VALID,
	output logic TX_READY,
	input wire logic [7:0] TX_DATA,
	// Receive data
	output logic RX_VALID,
	input wire logic RX_READY,
	output ast_pkg::ast_rx_entry_t RX_DATA,
	// Status
	output logic BUSY,
	output logic [$clog2(DEPTH):0] RX_LEVEL,
	// Serial pins
	input wire logic RXD,
	output logic TXD,
	input wire logic CTS_N,
	output logic RTS_N
);
	localparam int LW = $clog2(DEPTH) + 1;
	localparam logic [LW-1:0] ONE = LW'(1);
	localparam logic [LW-1:0] FULL = LW'(DEPTH);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic rx_meta;
	logic rx_sync;
	logic cts_meta;
	logic cts_sync;
	always_ff @(posedge CLK) begin
		if (RST) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			cts_meta <= 1'b1;
			cts_sync <= 1'b1;
		end else begin
			rx_meta <= RXD;
			rx_sync <= rx_meta;
			cts_meta <= CTS_N;
			cts_sync <= cts_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fractional oversample tick: period integer + fraction/64 clocks
	logic [`AST_INT_W-1:0] div_cnt;
	logic [`AST_FRAC_W-1:0] frac_acc;
	logic [`AST_FRAC_W:0] frac_sum;
	logic oversample_tick;
	logic [4:0] ovs_len;
	assign frac_sum = {1'b0, frac_acc} + {1'b0, DIVISOR_FRACTION};
	assign ovs_len = OVERSAMPLE_SELECT ? `AST_OVS_FAST : `AST_OVS_NORMAL;
	// One-clock tick, stretched by a clock when the fraction carries
	always_ff @(posedge CLK) begin
		if (RST) begin
			div_cnt <= '0;
			frac_acc <= '0;
			oversample_tick <= 1'b0;
		end else begin
			oversample_tick <= 1'b0;
			if (div_cnt <= 16'h0001) begin
				oversample_tick <= (DIVISOR_INTEGER != '0);
				frac_acc <= frac_sum[`AST_FRAC_W-1:0];
				div_cnt <= frac_sum[`AST_FRAC_W] ? DIVISOR_INTEGER + 16'h0001 : DIVISOR_INTEGER;
			end else begin
				div_cnt <= div_cnt - 16'h0001;
			end
		end
	end

	// Data bit count for the given length code, 5 to 8; excludes start, parity and stop
	function automatic logic [3:0] data_bits(input logic [1:0] code);
		data_bits = 4'h5 + {2'b00, code};
	endfunction : data_bits

	// Parity bit for a byte masked to the character length
	function automatic logic parity_of(input logic [7:0] d, input ast_pkg::ast_line_t lc);
		logic [7:0] m;
		m = 8'hff >> (2'h3 - lc.word_len);
		if (lc.stick_sel) begin
			parity_of = !lc.even_sel;
		end else begin
			parity_of = (^(d & m)) ^ !lc.even_sel;
		end
	endfunction : parity_of

	////////////////////////////////////////////////////////////////////////////
	// Transmit FIFO
	logic tx_out_valid;
	logic tx_pop;
	logic [7:0] tx_head;
	logic [LW-1:0] tx_level;
	logic tx_in_ready;
	ast_fifo #(.WIDTH(`AST_TX_WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
		.clk(CLK),
		.rst(RST),
		.limit(FIFO_ENABLE ? FULL : ONE),
		.in_valid(TX_VALID),
		.in_ready(tx_in_ready),
		.in_data(TX_DATA),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_head),
		.level(tx_level)
	);
	assign TX_READY = tx_in_ready;

	////////////////////////////////////////////////////////////////////////////
	// Transmitter
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA_S, TX_PAR, TX_STOP} ast_tx_state_t;
	ast_tx_state_t tx_state;
	logic [4:0] tx_tick;
	logic [7:0] tx_shift;
	logic [3:0] tx_bit;
	logic tx_par;
	logic tx_line;
	logic tx_bit_end;
	logic tx_go;
	assign tx_bit_end = oversample_tick && (tx_tick == ovs_len - 5'h01);
	// Start only when enabled, data waits, peer allows, no soft hold
	assign tx_go = ENABLE && tx_out_valid && !(CTS_FLOW_ENABLE && cts_sync) && !XOFF_HOLD;
	assign tx_pop = (tx_state == TX_IDLE) && tx_go;
	always_ff @(posedge CLK) begin
		if (RST) begin
			tx_state <= TX_IDLE;
			tx_tick <= '0;
			tx_shift <= '0;
			tx_bit <= '0;
			tx_par <= 1'b0;
			tx_line <= 1'b1;
		end else begin
			if (oversample_tick) begin
				tx_tick <= tx_bit_end ? 5'h00 : tx_tick + 5'h01;
			end
			unique case (tx_state)
				TX_IDLE: begin
					tx_line <= 1'b1;
					if (tx_go) begin
						tx_shift <= tx_head;
						tx_par <= parity_of(tx_head, TX_LINE_CONTROL);
						tx_tick <= '0;
						tx_line <= 1'b0;
						tx_state <= TX_START;
					end
				end
				TX_START: begin
					if (tx_bit_end) begin
						tx_line <= tx_shift[0];
						tx_shift <= tx_shift >> 1;
						tx_bit <= 4'h1;
						tx_state <= TX_DATA_S;
					end
				end
				TX_DATA_S: begin
					if (tx_bit_end) begin
						if (tx_bit == data_bits(TX_LINE_CONTROL.word_len)) begin
							tx_line <= TX_LINE_CONTROL.parity_en ? tx_par : 1'b1;
							tx_bit <= '0;
							tx_state <= TX_LINE_CONTROL.parity_en ? TX_PAR : TX_STOP;
						end else begin
							tx_line <= tx_shift[0];
							tx_shift <= tx_shift >> 1;
							tx_bit <= tx_bit + 4'h1;
						end
					end
				end
				TX_PAR: begin
					if (tx_bit_end) begin
						tx_line <= 1'b1;
						tx_state <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_bit_end) begin
						if (TX_LINE_CONTROL.two_stop && tx_bit == 4'h0) begin
							tx_bit <= 4'h1;
						end else begin
							tx_bit <= '0;
							tx_state <= TX_IDLE;
						end
					end
				end
			endcase
		end
	end
	// Line output with forced break
	always_ff @(posedge CLK) begin
		if (RST) begin
			TXD <= 1'b1;
		end else begin
			TXD <= tx_line && !TX_LINE_CONTROL.send_break;
		end
	end
	// Busy while data queued or a frame on the wire, enable ignored
	always_ff @(posedge CLK) begin
		if (RST) begin
			BUSY <= 1'b0;
		end else begin
			BUSY <= TX_VALID || tx_out_valid || (tx_state != TX_IDLE && !tx_pop);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ast_rx_state_t;
	ast_rx_state_t rx_state;
	logic [4:0] rx_tick;
	logic [3:0] rx_bit;
	logic [3:0] rx_total;
	logic [7:0] rx_shift;
	logic [2:0] rx_votes;
	logic rx_par_got;
	logic rx_zero;
	logic rx_done;
	logic rx_prev;
	logic pend_overrun;
	ast_pkg::ast_rx_entry_t rx_word;
	logic rx_in_ready;
	logic [4:0] mid;
	logic vote;
	assign mid = ovs_len >> 1;
	assign vote = (rx_votes[0] & rx_votes[1]) | (rx_votes[1] & rx_votes[2]) | (rx_votes[0] & rx_votes[2]);
	// Data, optional parity, one stop
	assign rx_total = data_bits(RX_LINE_CONTROL.word_len) + {3'b000, RX_LINE_CONTROL.parity_en} + 4'h1;
	always_ff @(posedge CLK) begin
		if (RST) begin
			rx_state <= RX_IDLE;
			rx_tick <= '0;
			rx_bit <= '0;
			rx_shift <= '0;
			rx_votes <= 3'h7;
			rx_par_got <= 1'b0;
			rx_zero <= 1'b1;
			rx_done <= 1'b0;
			rx_prev <= 1'b1;
			rx_word <= '0;
		end else begin
			rx_done <= 1'b0;
			rx_prev <= rx_sync;
			unique case (rx_state)
				RX_IDLE: begin
					if (ENABLE && rx_prev && !rx_sync) begin
						rx_tick <= '0;
						rx_state <= RX_START;
					end
				end
				RX_START: begin
					if (oversample_tick) begin
						rx_tick <= rx_tick + 5'h01;
						if (rx_tick == {1'b0, `AST_START_CHECK} && rx_sync) begin
							rx_state <= RX_IDLE;
						end else if (rx_tick == ovs_len - 5'h01) begin
							// Start bit over: bit timing restarts at the first data bit
							rx_tick <= '0;
							rx_bit <= '0;
							rx_zero <= 1'b1;
							rx_state <= RX_BITS;
						end
					end
				end
				RX_BITS: begin
					if (oversample_tick) begin
						rx_tick <= (rx_tick == ovs_len - 5'h01) ? 5'h00 : rx_tick + 5'h01;
						// Three samples centred on the bit middle
						if (rx_tick == mid - 5'h02 || rx_tick == mid - 5'h01 || rx_tick == mid) begin
							rx_votes <= {rx_votes[1:0], rx_sync};
						end
						if (rx_tick == mid + 5'h01) begin
							rx_bit <= rx_bit + 4'h1;
							if (vote) begin
								rx_zero <= 1'b0;
							end
							if (rx_bit < data_bits(RX_LINE_CONTROL.word_len)) begin
								rx_shift <= {vote, rx_shift[7:1]};
							end else if (rx_bit + 4'h1 < rx_total) begin
								rx_par_got <= vote;
							end
							if (rx_bit + 4'h1 == rx_total) begin
								// Align short characters to bit 0
								rx_word.data <= rx_shift >> (2'h3 - RX_LINE_CONTROL.word_len);
								rx_word.frame_err <= !vote;
								rx_word.parity_err <= RX_LINE_CONTROL.parity_en &&
									(rx_par_got != parity_of(rx_shift >> (2'h3 - RX_LINE_CONTROL.word_len), RX_LINE_CONTROL));
								rx_word.brk <= rx_zero && !vote;
								rx_done <= 1'b1;
								// Idle after every frame; a line held low gives no new edge
								rx_state <= RX_IDLE;
								rx_tick <= '0;
							end
						end
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end
	logic rx_room;
	// Disabled buffering counts the output stage as the single holding entry
	assign rx_room = rx_in_ready && (FIFO_ENABLE || !RX_VALID);
	// Overrun latched when the FIFO cannot take a completed character
	always_ff @(posedge CLK) begin
		if (RST) begin
			pend_overrun <= 1'b0;
		end else if (rx_done) begin
			pend_overrun <= !rx_room;
		end
	end
	logic rx_push;
	assign rx_push = rx_done && rx_room;
	// Receive FIFO
	ast_pkg::ast_rx_entry_t rx_entry;
	logic [`AST_RX_WIDTH-1:0] rx_out;
	logic rx_out_valid;
	logic rx_pop;
	always_comb begin
		rx_entry = rx_word;
		rx_entry.overrun = pend_overrun;
	end
	ast_fifo #(.WIDTH(`AST_RX_WIDTH), .DEPTH(DEPTH)) u_rx_fifo (
		.clk(CLK),
		.rst(RST),
		.limit(FIFO_ENABLE ? FULL : ONE),
		.in_valid(rx_push),
		.in_ready(rx_in_ready),
		.in_data(rx_entry),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_out),
		.level(RX_LEVEL)
	);
	// Registered output stage, refilled when the consumer takes the word
	assign rx_pop = rx_out_valid && (!RX_VALID || RX_READY);
	always_ff @(posedge CLK) begin
		if (RST) begin
			RX_VALID <= 1'b0;
			RX_DATA <= '0;
		end else if (!RX_VALID || RX_READY) begin
			RX_VALID <= rx_out_valid;
			RX_DATA <= rx_out;
		end
	end
	// Request to send, active low pin
	always_ff @(posedge CLK) begin
		if (RST) begin
			RTS_N <= 1'b1;
		end else begin
			RTS_N <= RTS_FLOW_ENABLE ? (RX_LEVEL >= RX_WATERMARK) : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_start_low;
		(rx_state == RX_START && oversample_tick && rx_tick == 5'h07 && !rx_sync);
	endsequence
	AST_START_VALID: assert property (@(posedge CLK) disable iff (RST)
		s_start_low |=> rx_state != RX_IDLE) else $error("valid start not taken");
	AST_FALSE_START: assert property (@(posedge CLK) disable iff (RST)
		(rx_state == RX_START && oversample_tick && rx_tick == 5'h07 && rx_sync) |=> rx_state == RX_IDLE)
		else $error("false start not discarded");
	AST_OVERRUN_DROP: assert property (@(posedge CLK) disable iff (RST)
		(rx_done && !rx_room) |=> pend_overrun && $stable(RX_LEVEL)) else $error("overrun lost");
	AST_OVERRUN_STORE: assert property (@(posedge CLK) disable iff (RST)
		(rx_push && pend_overrun) |=> !pend_overrun) else $error("overrun not cleared");
	AST_BUSY_RISE: assert property (@(posedge CLK) disable iff (RST)
		(TX_VALID && TX_READY) |=> BUSY) else $error("busy not raised");
	AST_BUSY_FALL: assert property (@(posedge CLK) disable iff (RST)
		$fell(BUSY) |-> (tx_level == '0 && tx_state == TX_IDLE)) else $error("busy fell early");
	AST_IDLE_HIGH: assert property (@(posedge CLK) disable iff (RST)
		(tx_state == TX_IDLE && !tx_go && !TX_LINE_CONTROL.send_break) |=> TXD) else $error("idle low");
	AST_BREAK_TX: assert property (@(posedge CLK) disable iff (RST)
		TX_LINE_CONTROL.send_break |=> !TXD) else $error("break not driven");
	AST_CTS_HOLD: assert property (@(posedge CLK) disable iff (RST)
		(CTS_FLOW_ENABLE && cts_sync) |-> !tx_pop) else $error("start while cts off");
	AST_HOLDING: assert property (@(posedge CLK) disable iff (RST)
		!FIFO_ENABLE && RX_LEVEL <= ONE |=> RX_LEVEL <= ONE) else $error("holding overflow");
endmodule : ast_uart

// [ast_defines.svh]
// Timing counts, field positions and sizes for the serial transceiver.
// Assumes inclusion by bare name from the transceiver design file.
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH
`define AST_CLK_MHZ 250
`define AST_MAX_BPS 2000000
`define AST_FIFO_DEPTH 64
`define AST_TX_WIDTH 8
`define AST_RX_WIDTH 12
`define AST_BIT_FE 8
`define AST_BIT_PE 9
`define AST_BIT_BE 10
`define AST_BIT_OE 11
`define AST_INT_W 16
`define AST_FRAC_W 6
`define AST_OVS_NORMAL 5'h10
`define AST_OVS_FAST 5'h08
`define AST_START_CHECK 4'h7
`endif

// [ast_pkg.sv]
// Types shared by the serial transceiver.
// Assumes ast_defines.svh is on the include path.
package ast_pkg;
	// Line format: length code 0..3 means 5..8 bits
	typedef struct packed {
		logic [1:0] word_len;
		logic parity_en;
		logic even_sel;
		logic stick_sel;
		logic two_stop;
		logic send_break;
	} ast_line_t;
	// Receive FIFO entry
	typedef struct packed {
		logic overrun;
		logic brk;
		logic parity_err;
		logic frame_err;
		logic [7:0] data;
	} ast_rx_entry_t;
endpackage : ast_pkg

// [ast_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ast_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Limit of usable entries (1 models a holding register)
	input wire logic [$clog2(DEPTH):0] limit,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;
	assign in_ready = (level < limit);
	assign out_valid = (level != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	// Pointers and level
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule : ast_fifo

// [ast_remote.sv]
// Remote serial device: drives frames onto RXD and decodes frames seen on TXD.
// Assumes the bench sets bit time in clocks and the data-plus-parity bit count.
`timescale 1ns/1ps
module ast_remote (
	// Clock and line format
	input wire logic clk,
	input wire logic [15:0] bit_clks,
	input wire logic [3:0] nbits,
	// Serial lines
	input wire logic txd,
	output logic rxd
);
	logic [11:0] bits_q[$];
	time start_q[$];
	// Line idles high between frames
	initial rxd = 1'b1;
	////////////////////////////////////////
	// Decode each frame from mid start bit, first stop bit lands at index nbits
	initial begin : decode
		logic [11:0] v;
		forever begin
			@(negedge txd);
			start_q.push_back($time);
			repeat (bit_clks / 2) @(posedge clk);
			v = '0;
			for (int i = 0; i <= nbits; i++) begin
				repeat (bit_clks) @(posedge clk);
				v[i] = txd;
			end
			bits_q.push_back(v);
		end
	end
	////////////////////////////////////////
	// Start bit then n bits LSB first; bit g gets a one-clock glitch mid-bit
	task automatic send(input logic [11:0] b, input int n, input int g);
		rxd <= 1'b0;
		repeat (bit_clks) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			rxd <= b[i];
			repeat (bit_clks / 2) @(posedge clk);
			if (i == g) rxd <= ~b[i];
			@(posedge clk);
			rxd <= b[i];
			repeat (bit_clks / 2 - 1) @(posedge clk);
		end
		rxd <= 1'b1;
		@(posedge clk);
	endtask : send
	// Short low pulse that must not count as a start bit
	task automatic false_start(input int w);
		rxd <= 1'b0;
		repeat (w) @(posedge clk);
		rxd <= 1'b1;
		@(posedge clk);
	endtask : false_start
endmodule : ast_remote

// [ast_tb.sv]
// Self-checking bench for the serial transceiver against a remote line model.
// Assumes ast_pkg, ast_fifo, ast_uart and ast_remote are compiled first.
`timescale 1ns/1ps
module testbench;
	logic clk;
	logic rst = 1'b1;
	logic enable = 1'b1;
	logic fifo_en = 1'b1;
	logic ovs = 1'b0;
	ast_pkg::ast_line_t tx_lc = '0;
	ast_pkg::ast_line_t rx_lc = '0;
	logic rts_en = 1'b0;
	logic cts_en = 1'b0;
	logic cts_n = 1'b0;
	logic [6:0] wmark = 7'h02;
	logic xoff = 1'b0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic rx_ready = 1'b0;
	logic [15:0] bit_clks = 16'h0020;
	logic [3:0] nbits = 4'h5;
	logic tx_ready, rx_valid, busy, txd, rxd, rts_n;
	ast_pkg::ast_rx_entry_t rx_data;
	logic [6:0] rx_level;
	logic [11:0] e;
	int failures = 0;
	int num_checks = 0;
	// Formats: 5 none, 6 even, 7 odd two stops, 8 stick one, 8 stick zero two stops
	ast_pkg::ast_line_t cfg[5] = '{7'h00, 7'h38, 7'h52, 7'h74, 7'h7e};
	////////////////////////////////////////
	// Device and remote partner; tick every 2 clocks
	ast_uart #(.DEPTH(64)) i_dut (.CLK(clk), .RST(rst), .ENABLE(enable), .FIFO_ENABLE(fifo_en),
		.DIVISOR_INTEGER(16'h0002), .DIVISOR_FRACTION(6'h00), .OVERSAMPLE_SELECT(ovs),
		.TX_LINE_CONTROL(tx_lc), .RX_LINE_CONTROL(rx_lc), .RTS_FLOW_ENABLE(rts_en),
		.CTS_FLOW_ENABLE(cts_en), .RX_WATERMARK(wmark), .XOFF_HOLD(xoff),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data), .RX_VALID(rx_valid),
		.RX_READY(rx_ready), .RX_DATA(rx_data), .BUSY(busy), .RX_LEVEL(rx_level),
		.RXD(rxd), .TXD(txd), .CTS_N(cts_n), .RTS_N(rts_n));
	ast_remote i_remote (.clk(clk), .bit_clks(bit_clks), .nbits(nbits), .txd(txd), .rxd(rxd));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////
	// Line bits after start: data LSB first, parity, stops high
	function automatic logic [11:0] fmt(input logic [7:0] d, input ast_pkg::ast_line_t lc);
		int len;
		logic p;
		len = 5 + lc.word_len;
		p = ^(d & ((8'h01 << len) - 8'h01));
		fmt = 12'hfff;
		for (int i = 0; i < len; i++) fmt[i] = d[i];
		if (lc.parity_en) fmt[len] = lc.stick_sel ? !lc.even_sel : (lc.even_sel ? p : !p);
	endfunction : fmt
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			failures++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	// Counts and verdict
	task automatic stop_test;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// Push bytes holding valid until each is taken
	task automatic burst(input logic [7:0] q[$]);
		int w;
		w = 0;
		for (int i = 0; i < q.size(); i++) begin
			tx_valid <= 1'b1;
			tx_data <= q[i];
			@(posedge clk);
			while (tx_ready !== 1'b1 && w < 4000) begin
				@(posedge clk);
				w++;
			end
			if (w >= 4000) failures++;
		end
		tx_valid <= 1'b0;
		@(posedge clk);
	endtask : burst
	// Take one receive entry at the handshake edge
	task automatic pop(output logic [11:0] v);
		int w;
		w = 0;
		while (rx_valid !== 1'b1 && w < 2000) begin
			@(posedge clk);
			w++;
		end
		if (w >= 2000) failures++;
		rx_ready <= 1'b1;
		@(posedge clk);
		v = rx_data;
		rx_ready <= 1'b0;
		@(posedge clk);
	endtask : pop
	// Wait for busy to drop, bounded
	task automatic wait_idle;
		int w;
		w = 0;
		while (busy !== 1'b0 && w < 30000) begin
			@(posedge clk);
			w++;
		end
		if (w >= 30000) failures++;
	endtask : wait_idle
	// Empty the partner's records
	task automatic clear_remote;
		i_remote.bits_q.delete();
		i_remote.start_q.delete();
	endtask : clear_remote
	////////////////////////////////////////
	// One format: two frames out back to back, then good, bad parity, bad stop in
	task automatic t_format(input ast_pkg::ast_line_t lc, input logic [7:0] d);
		int n;
		logic [11:0] f;
		logic [11:0] m;
		logic [7:0] dm;
		n = 5 + lc.word_len + lc.parity_en;
		f = fmt(d, lc);
		m = ~(12'hffe << n);
		dm = d & ~(8'hff << (5 + lc.word_len));
		tx_lc <= lc;
		rx_lc <= lc;
		nbits <= 4'(n);
		clear_remote();
		@(posedge clk);
		burst('{d, ~d});
		wait_idle();
		check(i_remote.bits_q.size(), 2);
		check(i_remote.bits_q[0], f & m);
		check(i_remote.bits_q[1], fmt(~d, lc) & m);
		check(int'((i_remote.start_q[1] - i_remote.start_q[0]) / (4.0 * bit_clks)),
			n + 2 + lc.two_stop);
		i_remote.send(f, n + 1 + lc.two_stop, (lc.word_len == 2'h3) ? 2 : -1);
		pop(e);
		check(e, {4'h0, dm});
		if (lc.parity_en) begin
			i_remote.send(f ^ (12'h001 << (n - 1)), n + 1 + lc.two_stop, -1);
			pop(e);
			check(e, {4'h2, dm});
		end
		i_remote.send(f & ~(12'h001 << n), n + 1 + lc.two_stop, -1);
		pop(e);
		check(e, {4'h1, dm});
	endtask : t_format
	// Fill the transmit buffer while disabled, then let it drain
	task automatic t_fill;
		logic [7:0] q[$];
		for (int i = 0; i < 64; i++) q.push_back(8'(i * 3));
		enable <= 1'b0;
		tx_lc <= '0;
		nbits <= 4'h5;
		clear_remote();
		@(posedge clk);
		for (int j = 0; j < 4; j++) burst(q[16 * j:16 * j + 15]);
		@(posedge clk);
		check(busy, 1'b1);
		check(tx_ready, 1'b0);
		repeat (200) @(posedge clk);
		check(txd, 1'b1);
		enable <= 1'b1;
		wait_idle();
		check(i_remote.bits_q.size(), 64);
		for (int i = 0; i < 64; i++) check(i_remote.bits_q[i], 12'h020 | (q[i] & 8'h1f));
	endtask : t_fill
	// Single holding register: second byte refused, dropped char flags overrun
	task automatic t_overrun;
		fifo_en <= 1'b0;
		enable <= 1'b0;
		@(posedge clk);
		burst('{8'h5a});
		check(tx_ready, 1'b0);
		enable <= 1'b1;
		wait_idle();
		i_remote.send(fmt(8'h11, cfg[3] & 7'h60), 9, -1);
		i_remote.send(fmt(8'h22, cfg[3] & 7'h60), 9, -1);
		pop(e);
		check(e, 12'h011);
		i_remote.send(fmt(8'h33, cfg[3] & 7'h60), 9, -1);
		pop(e);
		check(e, 12'h833);
		i_remote.send(fmt(8'h44, cfg[3] & 7'h60), 9, -1);
		pop(e);
		check(e, 12'h044);
		fifo_en <= 1'b1;
	endtask : t_overrun
	// Request-to-send follows the watermark
	task automatic t_rts;
		rts_en <= 1'b1;
		for (int i = 0; i < 3; i++) i_remote.send(12'hf00 | 8'(i), 9, -1);
		repeat (4) @(posedge clk);
		check(rts_n, 1'b1);
		pop(e);
		pop(e);
		repeat (4) @(posedge clk);
		check(rts_n, 1'b0);
		pop(e);
		check(e, 12'h002);
		rts_en <= 1'b0;
	endtask : t_rts
	// Clear-to-send gates new characters, current one completes
	task automatic t_cts;
		int w;
		w = 0;
		cts_en <= 1'b1;
		cts_n <= 1'b1;
		tx_lc <= '0;
		nbits <= 4'h5;
		clear_remote();
		@(posedge clk);
		burst('{8'h0a, 8'h15});
		repeat (400) @(posedge clk);
		check(txd, 1'b1);
		cts_n <= 1'b0;
		while (i_remote.start_q.size() == 0 && w < 400) begin
			@(posedge clk);
			w++;
		end
		cts_n <= 1'b1;
		repeat (800) @(posedge clk);
		check(i_remote.bits_q.size(), 1);
		check(i_remote.bits_q[0], 12'h02a);
		check(busy, 1'b1);
		cts_n <= 1'b0;
		wait_idle();
		check(i_remote.bits_q[1], 12'h035);
		xoff <= 1'b1;
		burst('{8'h03});
		repeat (400) @(posedge clk);
		check(i_remote.bits_q.size(), 2);
		xoff <= 1'b0;
		wait_idle();
		check(i_remote.bits_q.size(), 3);
		check(i_remote.bits_q[2], 12'h023);
		cts_en <= 1'b0;
	endtask : t_cts
	// Break both ways, and a false start ignored
	task automatic t_break;
		tx_lc <= 7'h01;
		repeat (100) @(posedge clk);
		check(txd, 1'b0);
		tx_lc <= '0;
		repeat (400) @(posedge clk);
		check(txd, 1'b1);
		clear_remote();
		i_remote.send(12'h000, 10, -1);
		pop(e);
		check(e, 12'h500);
		i_remote.false_start(8);
		repeat (96) @(posedge clk);
		check(rx_valid, 1'b0);
		i_remote.send(12'hf3c, 9, -1);
		pop(e);
		check(e, 12'h03c);
	endtask : t_break
	////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		check(txd, 1'b1);
		check(rts_n, 1'b1);
		check(busy, 1'b0);
		check(rx_valid, 1'b0);
		check(rx_data, 12'h000);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		check(rts_n, 1'b0);
		for (int k = 0; k < 5; k++) t_format(cfg[k], 8'hc6 ^ 8'(k * 37));
		ovs <= 1'b1;
		bit_clks <= 16'h0010;
		@(posedge clk);
		t_format(cfg[3], 8'h96);
		ovs <= 1'b0;
		bit_clks <= 16'h0020;
		rx_lc <= cfg[3] & 7'h60;
		t_fill();
		t_overrun();
		t_rts();
		t_cts();
		t_break();
		stop_test();
	end
	// Watchdog
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		stop_test();
	end
endmodule : testbench
